// [pmt_timer.sv]
// Period match timer: 8-bit counter, prescaler, period compare, postscaler.
// Assumes register strobes are one cycle, synchronous to clk, never both.
// Function
// - Readable, writable 8-bit count and period registers
// - Count from 00h on prescaled instruction clock ticks
// - Four-bit prescaler divides by one, four, sixteen
// - Compare count with period, flag match output
// - Counter returns to 00h after match
// - Postscaler fires once per select-plus-one matches
// - Reset clears count, loads period with FFh
// - Count, control writes and reset clear scalers
// - Control write leaves count value untouched
// - Control bit 2 runs or stops timer
// - Bit 7 reads zero; postscale 6:3, prescale 1:0
// - Match optionally routed as serial shift clock
// - Postscaler event latches match flag, enable gates
// - Unscaled match offered to compare/PWM units
//
// Strobed register access and the placing of the registers are this design's own decisions.
module pmt_timer
   import pmt_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [PMT_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Timer outputs
   output logic match_out,
   output logic serial_shift_clk,
   output logic irq
);
   logic [7:0] timer_control_reg;
   logic [7:0] timer_count_reg;
   logic [7:0] period_value_reg;
   logic match_flag_reg;
   logic match_irq_enable_reg;
   logic serial_route_reg;
   logic [1:0] osc_div_reg;
   logic [3:0] prescale_reg;
   logic [3:0] prescale_last;
   logic timer_run;
   logic instr_tick;
   logic count_tick;
   logic post_event;
   logic wr_control;
   logic wr_count;
   logic wr_flag;
   logic scaler_clear;

   assign wr_control = reg_write && reg_addr == PMT_OFF_CONTROL;
   assign wr_count = reg_write && reg_addr == PMT_OFF_COUNT;
   assign wr_flag = reg_write && reg_addr == PMT_OFF_FLAG;
   assign timer_run = timer_control_reg[PMT_CTL_RUN_BIT];
   assign scaler_clear = wr_control || wr_count;

   // Instruction clock: one enable pulse every fourth system clock
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_div_reg <= '0;
      end else begin
         osc_div_reg <= osc_div_reg + 2'h1;
      end
   end
   assign instr_tick = osc_div_reg == PMT_OSC_DIV_LAST;

   always_comb begin
      unique case (timer_control_reg[PMT_CTL_PRE_LSB +: 2])
         2'b00: prescale_last = PMT_PRE_LAST_1;
         2'b01: prescale_last = PMT_PRE_LAST_4;
         default: prescale_last = PMT_PRE_LAST_16;
      endcase
   end

   // Stopped timer holds the prescaler at zero, where the stopping control write left it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prescale_reg <= '0;
      end else if (scaler_clear) begin
         prescale_reg <= '0;
      end else if (timer_run && instr_tick) begin
         if (prescale_reg >= prescale_last) begin
            prescale_reg <= '0;
         end else begin
            prescale_reg <= prescale_reg + 4'h1;
         end
      end
   end
   assign count_tick = timer_run && instr_tick && !scaler_clear &&
      prescale_reg >= prescale_last;

   // Match is the compare result seen on a counting tick
   assign match_out = count_tick && timer_count_reg == period_value_reg;
   assign serial_shift_clk = serial_route_reg && match_out;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_count_reg <= PMT_COUNT_RST;
      end else if (wr_count) begin
         timer_count_reg <= reg_wdata;
      end else if (match_out) begin
         timer_count_reg <= '0;
      end else if (count_tick) begin
         timer_count_reg <= timer_count_reg + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         period_value_reg <= PMT_PERIOD_RST;
      end else if (reg_write && reg_addr == PMT_OFF_PERIOD) begin
         period_value_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_control_reg <= PMT_CONTROL_RST;
      end else if (wr_control) begin
         timer_control_reg <= reg_wdata & PMT_CTL_WMASK;
      end
   end

   pmt_postscaler #(.WIDTH(4)) u_post (
      .clk(clk),
      .reset_n(reset_n),
      .clear(scaler_clear),
      .step(match_out),
      .select(timer_control_reg[PMT_CTL_POST_LSB +: 4]),
      .event_out(post_event)
   );

   // Set wins over a clear written in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         match_flag_reg <= 1'b0;
      end else if (post_event) begin
         match_flag_reg <= 1'b1;
      end else if (wr_flag && !reg_wdata[PMT_FLAG_MATCH_BIT]) begin
         match_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         match_irq_enable_reg <= 1'b0;
         serial_route_reg <= 1'b0;
      end else if (reg_write) begin
         if (reg_addr == PMT_OFF_ENABLE) begin
            match_irq_enable_reg <= reg_wdata[PMT_FLAG_MATCH_BIT];
         end
         if (reg_addr == PMT_OFF_ROUTE) begin
            serial_route_reg <= reg_wdata[0];
         end
      end
   end

   assign irq = match_flag_reg && match_irq_enable_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         unique case (reg_addr)
            PMT_OFF_CONTROL: reg_rdata <= timer_control_reg;
            PMT_OFF_COUNT: reg_rdata <= timer_count_reg;
            PMT_OFF_PERIOD: reg_rdata <= period_value_reg;
            PMT_OFF_FLAG: reg_rdata <= {6'h00, match_flag_reg, 1'b0};
            PMT_OFF_ENABLE: reg_rdata <= {6'h00, match_irq_enable_reg, 1'b0};
            PMT_OFF_ROUTE: reg_rdata <= {7'h00, serial_route_reg};
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Counter and match behaviour
   a_match_restart: assert property (
      @(posedge clk) disable iff (!reset_n)
      match_out && !wr_count |=> timer_count_reg == 8'h00)
      else $error("counter not restarted after match");
   a_count_step: assert property (
      @(posedge clk) disable iff (!reset_n)
      count_tick && !match_out && !wr_count |=>
      timer_count_reg == $past(timer_count_reg) + 8'h01)
      else $error("counter did not advance on tick");
   a_stop_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !timer_run && !wr_count |=> $stable(timer_count_reg))
      else $error("stopped timer changed count");
   a_stop_nomatch: assert property (
      @(posedge clk) disable iff (!reset_n)
      !timer_run |-> !match_out)
      else $error("match while stopped");
   a_ctl_keep_count: assert property (
      @(posedge clk) disable iff (!reset_n)
      wr_control |=> timer_count_reg == $past(timer_count_reg))
      else $error("control write changed count");
   a_clear_prescale: assert property (
      @(posedge clk) disable iff (!reset_n)
      scaler_clear |=> prescale_reg == 4'h0)
      else $error("prescaler not cleared");
   a_bit7_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_read && reg_addr == PMT_OFF_CONTROL |=> reg_rdata[7] == 1'b0)
      else $error("control bit 7 not zero");
   a_flag_set: assert property (
      @(posedge clk) disable iff (!reset_n)
      post_event |=> match_flag_reg)
      else $error("flag not latched");
   a_tick_rate: assert property (
      @(posedge clk) disable iff (!reset_n)
      count_tick && timer_control_reg[1:0] == 2'b01 && !scaler_clear
      |=> !count_tick [*8])
      else $error("divide by four ticked early");
   a_irq_gate: assert property (
      @(posedge clk) disable iff (!reset_n)
      irq |-> match_flag_reg && match_irq_enable_reg)
      else $error("irq without enabled flag");
   a_match_eq: assert property (
      @(posedge clk) disable iff (!reset_n)
      match_out |-> timer_count_reg == period_value_reg)
      else $error("match without equality");
   a_count_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      wr_count |=> timer_count_reg == $past(reg_wdata))
      else $error("count write did not land");

   // Register side: writes land, reads answer one cycle later
   a_period_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_write && reg_addr == PMT_OFF_PERIOD |=>
      period_value_reg == $past(reg_wdata))
      else $error("period write did not land");
   a_period_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !(reg_write && reg_addr == PMT_OFF_PERIOD) |=>
      $stable(period_value_reg))
      else $error("period changed without a write");
   a_ctl_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      wr_control |=> timer_control_reg == ($past(reg_wdata) & PMT_CTL_WMASK))
      else $error("control write did not land");
   a_ctl_bit7: assert property (
      @(posedge clk) disable iff (!reset_n)
      timer_control_reg[7] == 1'b0)
      else $error("control bit 7 stored");
   a_rdata_idle: assert property (
      @(posedge clk) disable iff (!reset_n)
      !reg_read |=> reg_rdata == 8'h00)
      else $error("read data without a read");
   a_rdata_count: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_read && reg_addr == PMT_OFF_COUNT |=>
      reg_rdata == $past(timer_count_reg))
      else $error("count read wrong");
   a_rdata_period: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_read && reg_addr == PMT_OFF_PERIOD |=>
      reg_rdata == $past(period_value_reg))
      else $error("period read wrong");
   a_enable_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_write && reg_addr == PMT_OFF_ENABLE |=>
      match_irq_enable_reg == $past(reg_wdata[PMT_FLAG_MATCH_BIT]))
      else $error("enable write did not land");
   a_route_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_write && reg_addr == PMT_OFF_ROUTE |=>
      serial_route_reg == $past(reg_wdata[0]))
      else $error("route write did not land");

   // Tick chain: free divider, then the selected prescale ratio
   a_instr_gap: assert property (
      @(posedge clk) disable iff (!reset_n)
      instr_tick |=> !instr_tick [*3])
      else $error("instruction tick too early");
   a_instr_every: assert property (
      @(posedge clk) disable iff (!reset_n)
      instr_tick |-> ##4 instr_tick)
      else $error("instruction tick missing");
   a_osc_step: assert property (
      @(posedge clk) disable iff (!reset_n)
      1'b1 |=> osc_div_reg == $past(osc_div_reg) + 2'h1)
      else $error("divider did not run freely");
   a_div1_tick: assert property (
      @(posedge clk) disable iff (!reset_n)
      timer_run && instr_tick && !scaler_clear &&
      timer_control_reg[1:0] == 2'b00 |-> count_tick)
      else $error("divide by one missed a tick");
   a_pre_bound: assert property (
      @(posedge clk) disable iff (!reset_n)
      prescale_reg <= prescale_last)
      else $error("prescaler past its last value");
   a_pre_wrap: assert property (
      @(posedge clk) disable iff (!reset_n)
      timer_run && instr_tick && !scaler_clear &&
      prescale_reg >= prescale_last |=> prescale_reg == 4'h0)
      else $error("prescaler did not wrap");
   a_pre_step: assert property (
      @(posedge clk) disable iff (!reset_n)
      timer_run && instr_tick && !scaler_clear &&
      prescale_reg < prescale_last |=>
      prescale_reg == $past(prescale_reg) + 4'h1)
      else $error("prescaler did not count");
   a_pre_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !timer_run && !scaler_clear |=> $stable(prescale_reg))
      else $error("stopped prescaler moved");

   // Match flag: sticky until software writes a zero
   a_flag_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      match_flag_reg && !(wr_flag && !reg_wdata[PMT_FLAG_MATCH_BIT])
      |=> match_flag_reg)
      else $error("flag dropped without a clear");
   a_flag_clear: assert property (
      @(posedge clk) disable iff (!reset_n)
      wr_flag && !reg_wdata[PMT_FLAG_MATCH_BIT] && !post_event
      |=> !match_flag_reg)
      else $error("flag not cleared by zero write");
   a_flag_quiet: assert property (
      @(posedge clk) disable iff (!reset_n)
      !match_flag_reg && !post_event |=> !match_flag_reg)
      else $error("flag set without an event");
endmodule // pmt_timer

// [pmt_pkg.sv]
// Package for the period match timer: register map, field layout, resets.
// Assumes a 10 MHz system clock and a plain strobe register port.
package pmt_pkg;
   localparam int PMT_AW = 3;
   localparam logic [2:0] PMT_OFF_CONTROL = 3'h0;
   localparam logic [2:0] PMT_OFF_COUNT = 3'h1;
   localparam logic [2:0] PMT_OFF_PERIOD = 3'h2;
   localparam logic [2:0] PMT_OFF_FLAG = 3'h3;
   localparam logic [2:0] PMT_OFF_ENABLE = 3'h4;
   localparam logic [2:0] PMT_OFF_ROUTE = 3'h5;
   localparam int PMT_CTL_RUN_BIT = 2;
   localparam int PMT_CTL_POST_LSB = 3;
   localparam int PMT_CTL_PRE_LSB = 0;
   localparam int PMT_FLAG_MATCH_BIT = 1;
   localparam logic [7:0] PMT_CONTROL_RST = 8'h00;
   localparam logic [7:0] PMT_COUNT_RST = 8'h00;
   localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
   localparam logic [7:0] PMT_CTL_WMASK = 8'h7F;
   localparam logic [1:0] PMT_OSC_DIV_LAST = 2'h3;
   localparam logic [3:0] PMT_PRE_LAST_1 = 4'h0;
   localparam logic [3:0] PMT_PRE_LAST_4 = 4'h3;
   localparam logic [3:0] PMT_PRE_LAST_16 = 4'hF;
endpackage

// [pmt_postscaler.sv]
// Output postscaler: one event per (select + 1) input events.
// Assumes clear and step come from the timer core on the same clock.
module pmt_postscaler
   import pmt_pkg::*;
#(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic clear,
   input wire logic step,
   input wire logic [WIDTH-1:0] select,
   // Result
   output logic event_out
);
   logic [WIDTH-1:0] count_reg;

   assign event_out = step && !clear && (count_reg >= select);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (clear) begin
         count_reg <= '0;
      end else if (event_out) begin
         count_reg <= '0;
      end else if (step) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   a_post_wrap: assert property (
      @(posedge clk) disable iff (!reset_n)
      event_out |=> count_reg == '0)
      else $error("postscaler did not wrap");
   a_post_clear: assert property (
      @(posedge clk) disable iff (!reset_n)
      clear |=> count_reg == '0)
      else $error("postscaler not cleared");
   a_post_step: assert property (
      @(posedge clk) disable iff (!reset_n)
      step && !clear && !event_out |=> count_reg == $past(count_reg) + 1'b1)
      else $error("postscaler did not count");
endmodule // pmt_postscaler

// [tb.sv]
// Self-checking bench for the period match timer: registers, tick spacing,
// postscaler, interrupt flag and mask. Assumes pmt_pkg and pmt_timer.
module tb
   import pmt_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   // Design ports
   logic clk, reset_n, reg_write, reg_read;
   logic [PMT_AW-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic match_out, serial_shift_clk, irq;
   // Bench state
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic route_q;

   pmt_timer u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .match_out(match_out),
      .serial_shift_clk(serial_shift_clk), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Cycle stamp, read at falling edges so it is settled
   always @(posedge clk) cyc <= cyc + 1;

   task automatic final_report();
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                      input string nm);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp,
                     input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      chk({8'h00, reg_rdata}, {8'h00, exp}, nm);
   endtask

   task automatic wait_match(output int t);
      for (int i = 0; i < 20000; i++) begin
         @(negedge clk);
         if (match_out === 1'b1) begin
            chk({15'h0, serial_shift_clk}, {15'h0, route_q}, "shift");
            t = cyc;
            return;
         end
      end
      n_fail++;
      final_report();
   endtask

   initial begin
      int p, dv, t0, t1, n, post, hit;
      int posts[$];
      reset_n = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      route_q = 1'b0;
      void'($urandom(32'h7562));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      rd(PMT_OFF_CONTROL, 8'h00, "ctl rst");
      rd(PMT_OFF_COUNT, 8'h00, "cnt rst");
      rd(PMT_OFF_PERIOD, 8'hFF, "per rst");
      rd(PMT_OFF_FLAG, 8'h00, "flag rst");
      wr(3'h7, 8'hA5);
      rd(3'h7, 8'h00, "unmapped");
      wr(PMT_OFF_CONTROL, 8'hFF);
      rd(PMT_OFF_CONTROL, 8'h7F, "ctl bit7");
      wr(PMT_OFF_CONTROL, 8'h00);
      wr(PMT_OFF_PERIOD, 8'h07);
      wr(PMT_OFF_COUNT, 8'h07);
      rd(PMT_OFF_PERIOD, 8'h07, "period rw");
      n = 0;
      repeat (200) begin
         @(negedge clk);
         if (match_out === 1'b1) n++;
      end
      chk(n[15:0], 16'h0000, "stopped match");
      rd(PMT_OFF_COUNT, 8'h07, "stopped cnt");
      wr(PMT_OFF_CONTROL, 8'h03);
      rd(PMT_OFF_COUNT, 8'h07, "ctl keeps cnt");
      // Match spacing for every prescale code, shift route toggled
      for (int code = 0; code < 4; code++) begin
         dv = (code == 0) ? 1 : (code == 1) ? 4 : 16;
         p = (code == 0) ? 255 : int'($urandom_range(1, 30));
         route_q = code[0];
         wr(PMT_OFF_ROUTE, {7'h00, route_q});
         wr(PMT_OFF_PERIOD, p[7:0]);
         wr(PMT_OFF_COUNT, 8'h00);
         wr(PMT_OFF_CONTROL, {6'h01, code[1:0]});
         wait_match(t0);
         wait_match(t1);
         chk(16'(t1 - t0), 16'(4 * dv * (p + 1)), "spacing");
      end
      // Postscaler: boundaries plus one random ratio
      posts = '{0, 15};
      posts.push_back(int'($urandom_range(1, 14)));
      wr(PMT_OFF_PERIOD, 8'h01);
      foreach (posts[k]) begin
         post = posts[k];
         wr(PMT_OFF_CONTROL, 8'h00);
         wr(PMT_OFF_FLAG, 8'h00);
         wr(PMT_OFF_ENABLE, 8'h02);
         wr(PMT_OFF_CONTROL, {1'b0, post[3:0], 3'b100});
         n = 0;
         hit = 0;
         for (int i = 0; i < 2000; i++) begin
            @(negedge clk);
            if (irq === 1'b1) begin
               hit = 1;
               break;
            end
            if (match_out === 1'b1) n++;
         end
         if (hit == 0) begin
            n_fail++;
            final_report();
         end
         chk(n[15:0], 16'(post + 1), "post count");
         wr(PMT_OFF_ENABLE, 8'h00);
         @(negedge clk);
         chk({15'h0, irq}, 16'h0000, "masked irq");
         rd(PMT_OFF_FLAG, 8'h02, "flag set");
         wr(PMT_OFF_CONTROL, 8'h00);
         wr(PMT_OFF_FLAG, 8'h02);
         rd(PMT_OFF_FLAG, 8'h02, "flag w1");
         wr(PMT_OFF_FLAG, 8'h00);
         rd(PMT_OFF_FLAG, 8'h00, "flag clr");
      end
      final_report();
   end
endmodule // tb
